/* File: ebc_cfg.svh */
// Constants for the excitation and bias register bank.
// Assumes an APB master with 32-bit data and word-aligned accesses.
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH
`define EBC_AW 10
`define EBC_IDX_MAG 8'h06
`define EBC_IDX_ROUTE 8'h07
`define EBC_IDX_BIAS 8'h08
`define EBC_RST_MAG 8'h00
`define EBC_RST_ROUTE 8'hFF
`define EBC_RST_BIAS 8'h00
`define EBC_MAG_WMASK 8'hCF
`define EBC_BIT_RAIL 7
`define EBC_BIT_SWITCH 6
`define EBC_MAG_MSB 3
`define EBC_TWO_MSB 7
`define EBC_TWO_LSB 4
`define EBC_ONE_MSB 3
`define EBC_BIT_LEVEL 7
`define EBC_CONN_MSB 6
`define EBC_CODE_LAST_AIN 4'hB
`define EBC_CODE_REFP 4'h6
`define EBC_CODE_REFN 4'h7
`define EBC_CODE_LAST_SIX 4'h5
`define EBC_CODE_COMMON 4'hC
`define EBC_SLOT_COMMON 12
`define EBC_SLOT_REFP 13
`define EBC_SLOT_REFN 14
`endif

/* File: ebc_pkg.sv */
// Types shared by the excitation and bias register bank.
// Assumes ebc_cfg.svh is on the include path.
package ebc_pkg;
    typedef logic [7:0] ebc_byte_t;
    typedef logic [3:0] ebc_code_t;
    // One-hot pin slot: 0-11 inputs, 12 common, 13/14 second refs
    typedef logic [14:0] ebc_route_t;
    typedef logic [6:0] ebc_conn_t;
    typedef logic [9:0] ebc_addr_t;
endpackage

/* File: ebc_regs.sv */
// Excitation magnitude, excitation routing and sensor bias registers.
// Assumes an APB master on i_clk_sys and a power-down level from same-clock logic.
// The bus answers one cycle after setup; TWELVE_INPUTS picks the pin variant.
`timescale 1ns/10ps
`include "ebc_cfg.svh"

module ebc_regs #(
    parameter bit TWELVE_INPUTS = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire ebc_pkg::ebc_addr_t i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_power_down,
    output logic o_rail_monitor_enable,
    output logic o_low_side_switch_closed,
    output ebc_pkg::ebc_code_t o_excitation_magnitude,
    output ebc_pkg::ebc_route_t o_source_one_route,
    output ebc_pkg::ebc_route_t o_source_two_route,
    output logic o_bias_level_select,
    output ebc_pkg::ebc_conn_t o_bias_connect,
    output logic o_bias_enable
);
    import ebc_pkg::*;

    ebc_byte_t mag_reg;
    ebc_byte_t route_reg;
    ebc_byte_t bias_reg;
    ebc_byte_t rdata_next;
    logic hit_next;
    logic wr_fire;

    // Register index to byte address
    function automatic ebc_addr_t addr_of(input ebc_byte_t idx);
        addr_of = {idx, 2'b00};
    endfunction

    // Route code to one-hot pin slot; unknown codes leave it floating
    function automatic ebc_route_t decode_route(input ebc_code_t code);
        ebc_route_t r;
        r = '0;
        if (code == `EBC_CODE_COMMON) begin
            r[`EBC_SLOT_COMMON] = 1'b1;
        end else if (!TWELVE_INPUTS && code == `EBC_CODE_REFP) begin
            r[`EBC_SLOT_REFP] = 1'b1;
        end else if (!TWELVE_INPUTS && code == `EBC_CODE_REFN) begin
            r[`EBC_SLOT_REFN] = 1'b1;
        end else if (TWELVE_INPUTS && code <= `EBC_CODE_LAST_AIN) begin
            r[code] = 1'b1;
        end else if (code <= `EBC_CODE_LAST_SIX) begin
            r[code] = 1'b1;
        end
        decode_route = r;
    endfunction

    // Read mux and address decode for the setup cycle
    always_comb begin
        rdata_next = '0;
        hit_next = 1'b1;
        case (i_paddr)
            addr_of(`EBC_IDX_MAG): rdata_next = mag_reg & `EBC_MAG_WMASK;
            addr_of(`EBC_IDX_ROUTE): rdata_next = route_reg;
            addr_of(`EBC_IDX_BIAS): rdata_next = bias_reg;
            default: hit_next = 1'b0;
        endcase
    end

    assign wr_fire = i_psel && i_penable && o_pready && i_pwrite;

    // Accepted write aimed at one register index
    function automatic logic store_to(input logic fire, input ebc_addr_t addr, input ebc_byte_t idx);
        store_to = fire && (addr == addr_of(idx));
    endfunction

    // Answer is prepared in setup so the access phase has no wait state
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end else if (i_psel && !i_penable) begin
            o_pready <= 1'b1;
            o_pslverr <= !hit_next;
            o_prdata <= {24'h000000, rdata_next};
        end else begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Magnitude register; reserved bits never store
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            mag_reg <= `EBC_RST_MAG;
        end else if (store_to(wr_fire && !o_pslverr, i_paddr, `EBC_IDX_MAG)) begin
            mag_reg <= i_pwdata[7:0] & `EBC_MAG_WMASK;
        end
    end

    // Routing register
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            route_reg <= `EBC_RST_ROUTE;
        end else if (store_to(wr_fire && !o_pslverr, i_paddr, `EBC_IDX_ROUTE)) begin
            route_reg <= i_pwdata[7:0];
        end
    end

    // Bias register, all bits writable
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            bias_reg <= `EBC_RST_BIAS;
        end else if (store_to(wr_fire && !o_pslverr, i_paddr, `EBC_IDX_BIAS)) begin
            bias_reg <= i_pwdata[7:0];
        end
    end

    // Excitation controls; power-down overrides the stored switch bit
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_rail_monitor_enable <= 1'b0;
            o_low_side_switch_closed <= 1'b0;
            o_excitation_magnitude <= '0;
        end else begin
            o_rail_monitor_enable <= mag_reg[`EBC_BIT_RAIL];
            o_low_side_switch_closed <= mag_reg[`EBC_BIT_SWITCH] && !i_power_down;
            o_excitation_magnitude <= mag_reg[`EBC_MAG_MSB:0];
        end
    end

    // Route decode, one table shared by both sources
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_source_one_route <= '0;
            o_source_two_route <= '0;
        end else begin
            o_source_one_route <= decode_route(route_reg[`EBC_ONE_MSB:0]);
            o_source_two_route <= decode_route(route_reg[`EBC_TWO_MSB:`EBC_TWO_LSB]);
        end
    end

    // Bias drive; the source is idle when no input is selected
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_bias_level_select <= 1'b0;
            o_bias_connect <= '0;
            o_bias_enable <= 1'b0;
        end else begin
            o_bias_level_select <= bias_reg[`EBC_BIT_LEVEL];
            o_bias_connect <= bias_reg[`EBC_CONN_MSB:0];
            o_bias_enable <= |bias_reg[`EBC_CONN_MSB:0];
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    a_switch_pd_open: assert property (
        i_power_down |=> !o_low_side_switch_closed)
        else $error("low-side switch closed in power-down");

    a_switch_follows_bit: assert property (
        !i_power_down |=> o_low_side_switch_closed == $past(mag_reg[`EBC_BIT_SWITCH]))
        else $error("low-side switch does not follow control bit");

    a_rail_follows_bit: assert property (
        ##1 o_rail_monitor_enable == $past(mag_reg[`EBC_BIT_RAIL]))
        else $error("rail monitor enable wrong");

    a_reserved_zero: assert property (
        (i_psel && !i_penable && i_paddr == addr_of(`EBC_IDX_MAG)) |=> o_prdata[5:4] == 2'b00)
        else $error("reserved magnitude bits read nonzero");

    a_mag_write: assert property (
        (wr_fire && !o_pslverr && i_paddr == addr_of(`EBC_IDX_MAG)) |=> ##1
        o_excitation_magnitude == $past(i_pwdata[3:0], 2))
        else $error("magnitude not applied two cycles after write");

    a_route_off: assert property (
        (route_reg[`EBC_ONE_MSB:0] > `EBC_CODE_COMMON) |=> o_source_one_route == '0)
        else $error("source one connected on off code");

    a_route_onehot: assert property (
        ##1 $onehot0(o_source_one_route) && $onehot0(o_source_two_route))
        else $error("route drives more than one pin");

    a_route_reset: assert property (
        $rose(i_reset_n) |-> route_reg == `EBC_RST_ROUTE)
        else $error("routing register reset value wrong");

    a_bias_enable: assert property (
        ##1 o_bias_enable == (o_bias_connect != '0))
        else $error("bias enable disagrees with connections");

    a_pready_one: assert property (
        (i_psel && !i_penable) |=> o_pready ##1 !o_pready)
        else $error("pready not a single access cycle");

    // Bus answer and refusals
    a_pready_idle: assert property (
        !i_psel |=> !o_pready)
        else $error("pready raised without a request");

    a_pslverr_unmapped: assert property (
        (i_psel && !i_penable && !hit_next) |=> o_pslverr)
        else $error("unmapped address not refused");

    a_hit_no_err: assert property (
        (i_psel && !i_penable && hit_next) |=> !o_pslverr)
        else $error("mapped address refused");

    a_rdata_hold: assert property (
        !(i_psel && !i_penable) |=> $stable(o_prdata))
        else $error("read data changed outside a setup");

    a_refused_write: assert property (
        (wr_fire && o_pslverr) |=> $stable(mag_reg) && $stable(route_reg) && $stable(bias_reg))
        else $error("refused write changed a register");

    // Register stores and reset values
    a_mag_store: assert property (
        store_to(wr_fire && !o_pslverr, i_paddr, `EBC_IDX_MAG)
        |=> mag_reg == ($past(i_pwdata[7:0]) & `EBC_MAG_WMASK))
        else $error("magnitude write not stored");

    a_reserved_store: assert property (
        (mag_reg & ~`EBC_MAG_WMASK) == '0)
        else $error("reserved magnitude bits stored");

    a_route_store: assert property (
        store_to(wr_fire && !o_pslverr, i_paddr, `EBC_IDX_ROUTE)
        |=> route_reg == $past(i_pwdata[7:0]))
        else $error("routing write not stored");

    a_bias_store: assert property (
        store_to(wr_fire && !o_pslverr, i_paddr, `EBC_IDX_BIAS)
        |=> bias_reg == $past(i_pwdata[7:0]))
        else $error("bias write not stored");

    a_mag_reset: assert property (
        $rose(i_reset_n) |-> mag_reg == `EBC_RST_MAG)
        else $error("magnitude register reset value wrong");

    a_bias_reset: assert property (
        $rose(i_reset_n) |-> bias_reg == `EBC_RST_BIAS)
        else $error("bias register reset value wrong");

    a_mag_common: assert property (
        ##1 o_excitation_magnitude == $past(mag_reg[`EBC_MAG_MSB:0]))
        else $error("shared magnitude code not applied");

    // Route decode per variant
    a_twelve_input: assert property (
        (TWELVE_INPUTS && route_reg[`EBC_ONE_MSB:0] <= `EBC_CODE_LAST_AIN)
        |=> $onehot(o_source_one_route) && o_source_one_route[$past(route_reg[`EBC_ONE_MSB:0])])
        else $error("source one not on the selected input");

    a_two_common: assert property (
        (route_reg[`EBC_TWO_MSB:`EBC_TWO_LSB] == `EBC_CODE_COMMON) |=> o_source_two_route[`EBC_SLOT_COMMON])
        else $error("source two not on common input");

    a_two_off: assert property (
        (route_reg[`EBC_TWO_MSB:`EBC_TWO_LSB] > `EBC_CODE_COMMON) |=> o_source_two_route == '0)
        else $error("source two connected on off code");

    a_six_refp: assert property (
        (!TWELVE_INPUTS && route_reg[`EBC_ONE_MSB:0] == `EBC_CODE_REFP) |=> o_source_one_route[`EBC_SLOT_REFP])
        else $error("source one not on second positive reference");

    a_six_refn: assert property (
        (!TWELVE_INPUTS && route_reg[`EBC_TWO_MSB:`EBC_TWO_LSB] == `EBC_CODE_REFN)
        |=> o_source_two_route[`EBC_SLOT_REFN])
        else $error("source two not on second negative reference");

    a_six_upper_off: assert property (
        (!TWELVE_INPUTS && route_reg[`EBC_ONE_MSB:0] > `EBC_CODE_REFN
        && route_reg[`EBC_ONE_MSB:0] <= `EBC_CODE_LAST_AIN) |=> o_source_one_route == '0)
        else $error("six-input variant connected a missing input");

    // Bias drive
    a_bias_level: assert property (
        ##1 o_bias_level_select == $past(bias_reg[`EBC_BIT_LEVEL]))
        else $error("bias level not applied");

    a_bias_idle: assert property (
        (bias_reg[`EBC_CONN_MSB:0] == '0) |=> !o_bias_enable)
        else $error("bias enabled with no input selected");

    // One check per connection bit; any mix may be set at once
    for (genvar k = 0; k <= `EBC_CONN_MSB; k++) begin : g_bias_bit
        a_bias_bit: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
            ##1 o_bias_connect[k] == $past(bias_reg[k]))
            else $error("bias connection bit not applied");
    end

    c_mag_write: cover property (wr_fire && i_paddr == addr_of(`EBC_IDX_MAG));
    c_route_common: cover property (o_source_two_route[`EBC_SLOT_COMMON]);
    c_pd_override: cover property (mag_reg[`EBC_BIT_SWITCH] && i_power_down);
    c_bias_many: cover property (o_bias_enable && !$onehot(o_bias_connect));
    c_six_ref: cover property (o_source_one_route[`EBC_SLOT_REFP]);
endmodule

/* File: test_excitation_bias_config_regs.sv */
// Self-checking bench for the excitation and bias register bank.
// Assumes ebc_pkg and ebc_regs are compiled first; APB has zero wait states.
`timescale 1ns/10ps
module test_excitation_bias_config_regs;
    import ebc_pkg::*;
    typedef struct {ebc_addr_t addr; logic [7:0] wr; logic [31:0] rd;} ebc_row_t;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    ebc_addr_t i_paddr = 10'h000;
    logic [31:0] i_pwdata = 32'h00000000;
    logic i_power_down = 1'b0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_rail_monitor_enable, o_low_side_switch_closed, o_bias_level_select, o_bias_enable;
    ebc_code_t o_excitation_magnitude;
    ebc_route_t o_source_one_route, o_source_two_route;
    ebc_conn_t o_bias_connect;
    ebc_route_t six_one_route, six_two_route;
    int bad_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic err;
    // Upper write bits are set on purpose; readback must ignore them
    ebc_row_t rows [5] = '{'{10'h018, 8'hFF, 32'h000000CF}, '{10'h018, 8'h3A, 32'h0000000A},
        '{10'h01C, 8'h5C, 32'h0000005C}, '{10'h020, 8'hA5, 32'h000000A5}, '{10'h020, 8'h7F, 32'h0000007F}};

    ebc_regs #(.TWELVE_INPUTS(1'b1)) ebc_regs_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_power_down(i_power_down),
        .o_rail_monitor_enable(o_rail_monitor_enable), .o_low_side_switch_closed(o_low_side_switch_closed),
        .o_excitation_magnitude(o_excitation_magnitude), .o_source_one_route(o_source_one_route),
        .o_source_two_route(o_source_two_route), .o_bias_level_select(o_bias_level_select),
        .o_bias_connect(o_bias_connect), .o_bias_enable(o_bias_enable));

    // Six-input variant shares the bus; only its route decode is watched
    ebc_regs #(.TWELVE_INPUTS(1'b0)) ebc_regs_six_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(), .o_pready(), .o_pslverr(), .i_power_down(i_power_down),
        .o_rail_monitor_enable(), .o_low_side_switch_closed(),
        .o_excitation_magnitude(), .o_source_one_route(six_one_route),
        .o_source_two_route(six_two_route), .o_bias_level_select(),
        .o_bias_connect(), .o_bias_enable());

    // 100 MHz clock
    always #5 i_clk_sys = ~i_clk_sys;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input ebc_addr_t a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= {24'hFFFFFF, d};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 20) begin
            chk("pready_wait", {31'h0, o_pready}, 32'h1);
            wrap_up();
        end
    endtask

    // Outputs follow a stored write two edges later
    task automatic settle();
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask

    function automatic ebc_route_t pin(input ebc_code_t c);
        return (c <= 4'hC) ? (15'h0001 << c) : 15'h0000;
    endfunction

    // Six-input pin map: codes 6/7 go to the second references
    function automatic ebc_route_t pin_six(input ebc_code_t c);
        if (c == 4'h6) return 15'h2000;
        if (c == 4'h7) return 15'h4000;
        if (c == 4'hC || c <= 4'h5) return 15'h0001 << c;
        return 15'h0000;
    endfunction

    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        // Table of write then readback pairs
        foreach (rows[k]) begin
            apb(1'b1, rows[k].addr, rows[k].wr);
            chk("wr_err", {31'h0, err}, 32'h0);
            apb(1'b0, rows[k].addr, 8'h00);
            chk("readback", rd, rows[k].rd);
        end
        $display("table rows done");
        // Magnitude controls and power-down override
        apb(1'b1, 10'h018, 8'hC8);
        settle();
        chk("rail", {31'h0, o_rail_monitor_enable}, 32'h1);
        chk("switch", {31'h0, o_low_side_switch_closed}, 32'h1);
        chk("mag", {28'h0, o_excitation_magnitude}, 32'h8);
        @(posedge i_clk_sys);
        i_power_down <= 1'b1;
        settle();
        chk("switch_pd", {31'h0, o_low_side_switch_closed}, 32'h0);
        chk("rail_pd", {31'h0, o_rail_monitor_enable}, 32'h1);
        @(posedge i_clk_sys);
        i_power_down <= 1'b0;
        settle();
        chk("switch_back", {31'h0, o_low_side_switch_closed}, 32'h1);
        $display("magnitude test done");
        // Every route code, fields carrying different codes
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 10'h01C, {c[3:0], ~c[3:0]});
            settle();
            chk("route_two", {17'h0, o_source_two_route}, {17'h0, pin(c[3:0])});
            chk("route_one", {17'h0, o_source_one_route}, {17'h0, pin(~c[3:0])});
            chk("six_two", {17'h0, six_two_route}, {17'h0, pin_six(c[3:0])});
            chk("six_one", {17'h0, six_one_route}, {17'h0, pin_six(~c[3:0])});
        end
        $display("route test done");
        // Bias level with and without connections
        apb(1'b1, 10'h020, 8'hC1);
        settle();
        chk("bias", {23'h0, o_bias_level_select, o_bias_enable, o_bias_connect}, 32'h000001C1);
        apb(1'b1, 10'h020, 8'h80);
        settle();
        chk("bias_off", {23'h0, o_bias_level_select, o_bias_enable, o_bias_connect}, 32'h00000100);
        // Unmapped and misaligned addresses are refused
        apb(1'b1, 10'h024, 8'h55);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b0, 10'h019, 8'h00);
        chk("misaligned", {rd[30:0], err}, 32'h1);
        $display("bias and refusal tests done");
        // Second reset restores documented values
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        #1;
        chk("rst_routes", {2'b00, o_source_one_route, o_source_two_route}, 32'h0);
        chk("rst_mag_out", {28'h0, o_excitation_magnitude}, 32'h0);
        chk("rst_ctrl", {28'h0, o_rail_monitor_enable, o_low_side_switch_closed, o_bias_level_select,
            o_bias_enable}, 32'h0);
        apb(1'b0, 10'h018, 8'h00);
        chk("rst_mag", rd, 32'h00000000);
        apb(1'b0, 10'h01C, 8'h00);
        chk("rst_route", rd, 32'h000000FF);
        apb(1'b0, 10'h020, 8'h00);
        chk("rst_bias", rd, 32'h00000000);
        $display("reset test done");
        wrap_up();
    end
endmodule
